// *** verilog/dpr_pkg.sv ***
// package: register map, field layout and timing constants of the protection register bank
package dpr_pkg;

	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned DEGLITCH_NS     = 1000;
	localparam int unsigned DEGLITCH_CYCLES = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned VOLTAGE_SELECT_BITS_W = 4;

	localparam logic [ADDR_W-1:0] ADDR_FAULT_FLAGS  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_VOLTAGE_SEL  = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_PROT_CONFIG  = 8'h05;

	localparam logic [DATA_W-1:0] PROT_CONFIG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] VOLTAGE_SEL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] PROT_CONFIG_MASK  = 8'hd9;
	localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;

	localparam int unsigned FLT_PULLDOWN_OVERCURRENT_A_BIT = 4;
	localparam int unsigned FLT_PULLDOWN_OVERCURRENT_B_BIT = 5;
	localparam int unsigned NUM_FAULTS    = 8;
	localparam int unsigned NUM_CH        = 2;

	// status layout, bit 0 first from the bottom
	typedef struct packed {
		logic vcc_low;
		logic overtemp_flag;
		logic pulldown_overcurrent_b;
		logic pulldown_overcurrent_a;
		logic out_voltage_low_b;
		logic out_voltage_low_a;
		logic overload_flag_b;
		logic overload_flag_a;
	} dpr_faults_t;

	// protection configuration layout
	typedef struct packed {
		logic comp_high_esr;
		logic thermal_latched_recovery;
		logic rsvd5;
		logic min_current_diag_en_b;
		logic overload_latched_recovery;
		logic rsvd2;
		logic rsvd1;
		logic min_current_diag_en_a;
	} dpr_config_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dpr_reg_req_t;

	typedef struct packed {
		logic              comp_high_esr;
		logic              min_current_diag_en_b;
		logic              level_21v_req_a;
		logic              out_en_b;
		logic              out_en_a;
		logic [VOLTAGE_SELECT_BITS_W-1:0] voltage_select_bits_b;
		logic [VOLTAGE_SELECT_BITS_W-1:0] voltage_select_bits_a;
	} dpr_supply_ctrl_t;

	typedef enum logic [2:0] {
		CH_ON    = 3'b001,
		CH_HOLD  = 3'b010,
		CH_LATCH = 3'b100
	} dpr_ch_state_t;

endpackage

// *** verilog/dpr_fault_cond.sv ***
// module: three-stage synchroniser for one fault pin with optional deglitch filter
`timescale 1ns/1ns
`default_nettype none

module dpr_fault_cond #(
	parameter int unsigned DEGLITCH = 0,
	parameter int unsigned CNT_W    = 12
) (
	input  wire logic clock_i,
	input  wire logic resetn_i,
	input  wire logic raw_i,
	output logic      level_o
);
	import dpr_pkg::*;

	logic             sync1_reg;
	logic             sync2_reg;
	logic             sync3_reg;
	logic             level_reg;
	logic [CNT_W-1:0] count_reg;

	if (DEGLITCH >= (1 << CNT_W)) begin : g_bad_width
		$error("deglitch count does not fit the counter");
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= raw_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// counts agreed-high cycles; level rises only once it passes the deglitch span
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			count_reg <= '0;
			level_reg <= 1'b0;
		end else if (sync2_reg == sync3_reg) begin
			if (!sync3_reg) begin
				count_reg <= '0;
				level_reg <= 1'b0;
			end else if (DEGLITCH == 0) begin
				level_reg <= 1'b1;
			end else if (count_reg >= CNT_W'(DEGLITCH)) begin
				level_reg <= 1'b1;
			end else begin
				count_reg <= count_reg + CNT_W'(1);
			end
		end
	end

	assign level_o = level_reg;

endmodule
`default_nettype wire

// *** verilog/dpr_protection_regs.sv ***
// module: protection configuration and fault status registers of the dual supply controller
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - read/write protection config at address 0x5
// - bits 0/4 enable diagnostic; A requests 21V
// - latched mode: overload clears select, disables channel
// - auto mode: overload clear restores channel, select kept
// - thermal latched: overtemp clears select, both off
// - thermal auto: restore both outputs with select
// - bit 7 drives converter compensation select
// - status register writes never change its contents
// - read-only fault status at address 0x0
// - bits 0/1 show channel overload
// - bits 2/3 show output voltage low
// - bit 4 pull-down overcurrent after deglitch
// - select field: A bits 0-3, B 4-7
// - bit 5 pull-down overcurrent channel B
// - bit 6 shared overtemperature flag
module dpr_protection_regs #(
	parameter int unsigned DEGLITCH = dpr_pkg::DEGLITCH_CYCLES
) (
	input  wire logic                      clock_i,
	input  wire logic                      resetn_i,
	input  wire dpr_pkg::dpr_reg_req_t     reg_req_i,
	output logic [dpr_pkg::DATA_W-1:0]     reg_rdata_o,
	output logic                           reg_rvalid_o,
	input  wire dpr_pkg::dpr_faults_t      faults_i,
	output dpr_pkg::dpr_supply_ctrl_t      supply_o
);
	import dpr_pkg::*;

	if (DEGLITCH == 0 || DEGLITCH >= 4096) begin : g_bad_deglitch
		$error("deglitch count must be between 1 and 4095");
	end

	dpr_config_t      config_reg;
	logic [DATA_W-1:0] voltage_select_bits_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic              rvalid_reg;
	dpr_faults_t       flags;
	dpr_faults_t       flags_prev_reg;
	dpr_supply_ctrl_t  supply_reg;
	dpr_ch_state_t     ch_state_reg [NUM_CH];
	dpr_ch_state_t     ch_state_next [NUM_CH];
	logic [NUM_CH-1:0] ol_now;
	logic [NUM_CH-1:0] ol_rise;
	logic              ot_rise;
	logic [NUM_CH-1:0] latch_trip;
	logic              voltage_select_bits_wr;
	logic              cfg_wr;
	logic              any_trip;

	function automatic logic hit(input dpr_reg_req_t req, input logic [ADDR_W-1:0] addr);
		hit = req.wr && (req.addr == addr);
	endfunction

	// conditioning of every fault pin; pull-down flags get the deglitch filter
	for (genvar i = 0; i < NUM_FAULTS; i++) begin : g_cond
		localparam int unsigned DG = (i == FLT_PULLDOWN_OVERCURRENT_A_BIT || i == FLT_PULLDOWN_OVERCURRENT_B_BIT) ? DEGLITCH : 0;
		dpr_fault_cond #(
			.DEGLITCH (DG),
			.CNT_W    (12)
		) u_cond (
			.clock_i  (clock_i),
			.resetn_i (resetn_i),
			.raw_i    (faults_i[i]),
			.level_o  (flags[i])
		);
	end

	assign voltage_select_bits_wr = hit(reg_req_i, ADDR_VOLTAGE_SEL);
	assign cfg_wr  = hit(reg_req_i, ADDR_PROT_CONFIG);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			flags_prev_reg <= '0;
		end else begin
			flags_prev_reg <= flags;
		end
	end

	assign ol_now  = {flags.overload_flag_b, flags.overload_flag_a};
	assign ol_rise = ol_now & ~{flags_prev_reg.overload_flag_b, flags_prev_reg.overload_flag_a};
	assign ot_rise = flags.overtemp_flag & ~flags_prev_reg.overtemp_flag;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			latch_trip[c] = (ol_rise[c] && config_reg.overload_latched_recovery)
				|| (ot_rise && config_reg.thermal_latched_recovery);
		end
	end

	assign any_trip = |latch_trip;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			config_reg <= PROT_CONFIG_RESET;
		end else if (cfg_wr) begin
			config_reg <= reg_req_i.wdata & PROT_CONFIG_MASK;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			voltage_select_bits_reg <= VOLTAGE_SEL_RESET;
		end else if (any_trip) begin
			voltage_select_bits_reg <= VOLTAGE_SEL_RESET;
		end else if (voltage_select_bits_wr) begin
			voltage_select_bits_reg <= reg_req_i.wdata;
		end
	end

	// per-channel output state
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ch_state_next[c] = ch_state_reg[c];
			unique case (ch_state_reg[c])
				CH_ON: begin
					if (latch_trip[c]) begin
						ch_state_next[c] = CH_LATCH;
					end else if (ol_now[c] || flags.overtemp_flag) begin
						ch_state_next[c] = CH_HOLD;
					end
				end
				CH_HOLD: begin
					if (latch_trip[c]) begin
						ch_state_next[c] = CH_LATCH;
					end else if (!ol_now[c] && !flags.overtemp_flag) begin
						ch_state_next[c] = CH_ON;
					end
				end
				CH_LATCH: begin
					if (voltage_select_bits_wr && !any_trip) begin
						if (ol_now[c] || flags.overtemp_flag) begin
							ch_state_next[c] = CH_HOLD;
						end else begin
							ch_state_next[c] = CH_ON;
						end
					end
				end
				default: begin
					ch_state_next[c] = CH_ON;
				end
			endcase
		end
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		always_ff @(posedge clock_i) begin
			if (!resetn_i) begin
				ch_state_reg[c] <= CH_ON;
			end else begin
				ch_state_reg[c] <= ch_state_next[c];
			end
		end
	end

	// supply control outputs from flops
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			supply_reg <= '0;
		end else begin
			supply_reg.voltage_select_bits_a <= voltage_select_bits_reg[VOLTAGE_SELECT_BITS_W-1:0];
			supply_reg.voltage_select_bits_b <= voltage_select_bits_reg[DATA_W-1:VOLTAGE_SELECT_BITS_W];
			supply_reg.out_en_a <= (ch_state_next[0] == CH_ON);
			supply_reg.out_en_b <= (ch_state_next[1] == CH_ON);
			supply_reg.level_21v_req_a       <= config_reg.min_current_diag_en_a;
			supply_reg.min_current_diag_en_b <= config_reg.min_current_diag_en_b;
			supply_reg.comp_high_esr <= config_reg.comp_high_esr;
		end
	end

	assign supply_o = supply_reg;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rdata_reg  <= READ_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				unique case (reg_req_i.addr)
					ADDR_FAULT_FLAGS: rdata_reg <= flags;
					ADDR_VOLTAGE_SEL: rdata_reg <= voltage_select_bits_reg;
					ADDR_PROT_CONFIG: rdata_reg <= config_reg;
					default:          rdata_reg <= READ_ZERO;
				endcase
			end
		end
	end

	assign reg_rdata_o  = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

endmodule
`default_nettype wire

// *** tb/dpr_protection_regs_asserts.sv ***
// checker: port-level properties of the protection register bank
`timescale 1ns/1ns
`default_nettype none
module dpr_protection_regs_asserts #(
	parameter int unsigned DEGLITCH = dpr_pkg::DEGLITCH_CYCLES
) (
	input wire logic                            clock_i,
	input wire logic                            resetn_i,
	input wire dpr_pkg::dpr_reg_req_t           reg_req_i,
	input wire logic [dpr_pkg::DATA_W-1:0]      reg_rdata_o,
	input wire logic                            reg_rvalid_o,
	input wire dpr_pkg::dpr_faults_t            faults_i,
	input wire dpr_pkg::dpr_supply_ctrl_t       supply_o
);
	import dpr_pkg::*;
	logic [7:0] cfg_reg;
	logic [7:0] hcnt_reg;
	wire logic  rd_st = reg_req_i.rd && reg_req_i.addr == ADDR_FAULT_FLAGS;
	wire logic  wr_cf = reg_req_i.wr && reg_req_i.addr == ADDR_PROT_CONFIG;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	always_ff @(posedge clock_i) begin
		if (!resetn_i) cfg_reg <= 8'h00;
		else if (wr_cf) cfg_reg <= reg_req_i.wdata;
	end
	always_ff @(posedge clock_i) begin
		if (!resetn_i || !faults_i.pulldown_overcurrent_a) hcnt_reg <= 8'h00;
		else if (hcnt_reg != 8'hff) hcnt_reg <= hcnt_reg + 8'h01;
	end
	AST_RVALID: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read got no valid");
	AST_CFG_RSVD: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_PROT_CONFIG |=>
		(reg_rdata_o & ~PROT_CONFIG_MASK) == 8'h00) else $error("reserved config bits set");
	AST_CFG_OUT: assert property (wr_cf |=> ##1 {supply_o.comp_high_esr, supply_o.min_current_diag_en_b,
		supply_o.level_21v_req_a} == {$past(reg_req_i.wdata[7], 2), $past(reg_req_i.wdata[4], 2),
		$past(reg_req_i.wdata[0], 2)}) else $error("config outputs wrong");
	AST_STATUS_LIVE: assert property (($stable(faults_i[3:0]))[*6] ##0 rd_st |=>
		reg_rdata_o[3:0] == $past(faults_i[3:0])) else $error("status flags wrong");
	AST_PDO_LOW: assert property ((!faults_i.pulldown_overcurrent_a)[*6] ##0 rd_st |=>
		!reg_rdata_o[4]) else $error("pulldown flag without cause");
	AST_PDO_HIGH: assert property (rd_st && hcnt_reg > DEGLITCH + 6 |=> reg_rdata_o[4])
		else $error("pulldown flag missing");
	AST_OL_OFF: assert property ((faults_i.overload_flag_a)[*8] |-> !supply_o.out_en_a)
		else $error("output on in overload");
	AST_OT_OFF: assert property ((faults_i.overtemp_flag)[*8] |->
		!supply_o.out_en_a && !supply_o.out_en_b) else $error("output on in overtemp");
	AST_VOLTAGE_SELECT_BITS_CLR: assert property ($rose(faults_i.overload_flag_a) ##0
		(cfg_reg[3] && faults_i.overload_flag_a && !reg_req_i.wr)[*8] |->
		{supply_o.voltage_select_bits_b, supply_o.voltage_select_bits_a} == 8'h00) else $error("select kept");
	cover property (rd_st ##1 reg_rdata_o[4]);
	cover property (wr_cf);
	cover property ($fell(supply_o.out_en_a));
endmodule
bind dpr_protection_regs dpr_protection_regs_asserts #(.DEGLITCH(DEGLITCH)) u_asserts (.clock_i(clock_i),
	.resetn_i(resetn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.faults_i(faults_i), .supply_o(supply_o));
`default_nettype wire

// *** tb/dpr_host_model.sv ***
// host bus master model issuing register requests
`timescale 1ns/1ns
`default_nettype none
module dpr_host_model (
	input  wire logic            clock_i,
	input  wire logic [7:0]      rdata_i,
	input  wire logic            rvalid_i,
	output dpr_pkg::dpr_reg_req_t req_o
);
	import dpr_pkg::*;
	initial req_o = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		req_o <= '{1'b1, 1'b0, a, (a == ADDR_PROT_CONFIG) ? (d & PROT_CONFIG_MASK) : d};
		@(posedge clock_i);
		req_o <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		req_o <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i);
		req_o <= '0;
		@(negedge clock_i);
		d = rvalid_i ? rdata_i : 8'hxx;
	endtask
endmodule
`default_nettype wire

// *** tb/dpr_protection_regs_tb.sv ***
// self-checking bench for the protection register bank
`timescale 1ns/1ns
`default_nettype none
module dpr_protection_regs_tb;
	import dpr_pkg::*;
	localparam int DG = 3;
	logic             clock_i = 1'b0;
	logic             resetn_i = 1'b0;
	dpr_reg_req_t     req;
	logic [7:0]       rdata;
	logic             rvalid;
	dpr_faults_t      faults = '0;
	dpr_supply_ctrl_t sup;
	logic [7:0]       d;
	int               fail_count = 0;
	int               tests_run = 0;
	always #4 clock_i = ~clock_i;
	dpr_protection_regs #(.DEGLITCH(DG)) u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .faults_i(faults), .supply_o(sup));
	dpr_host_model u_host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		@(negedge clock_i);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		chk(n, d, e);
	endtask
	task automatic trip(input logic [7:0] c, input logic [7:0] f, input logic [1:0] en,
			input logic [7:0] vs, input logic [1:0] en2);
		u_host.wr(ADDR_PROT_CONFIG, c);
		u_host.wr(ADDR_VOLTAGE_SEL, 8'h5a);
		faults <= f;
		cyc(10);
		chk("out_en", {6'h0, sup.out_en_b, sup.out_en_a}, {6'h0, en});
		chk("voltage_select_bits", {sup.voltage_select_bits_b, sup.voltage_select_bits_a}, vs);
		rchk("voltage_select_bits reg", ADDR_VOLTAGE_SEL, vs);
		@(posedge clock_i) faults <= '0;
		cyc(10);
		chk("out_en after", {6'h0, sup.out_en_b, sup.out_en_a}, {6'h0, en2});
		chk("voltage_select_bits after", {sup.voltage_select_bits_b, sup.voltage_select_bits_a}, vs);
		u_host.wr(ADDR_VOLTAGE_SEL, 8'h5a);
		cyc(2);
		chk("out_en rewrite", {6'h0, sup.out_en_b, sup.out_en_a}, 8'h03);
		chk("voltage_select_bits rewrite", {sup.voltage_select_bits_b, sup.voltage_select_bits_a}, 8'h5a);
	endtask
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clock_i);
		resetn_i <= 1'b1;
		rchk("cfg reset", ADDR_PROT_CONFIG, 8'h00);
		rchk("status reset", ADDR_FAULT_FLAGS, 8'h00);
		u_host.wr(ADDR_PROT_CONFIG, 8'h91);
		rchk("cfg", ADDR_PROT_CONFIG, 8'h91);
		chk("ctrl", {5'h0, sup.comp_high_esr, sup.min_current_diag_en_b, sup.level_21v_req_a}, 8'h07);
		u_host.wr(ADDR_PROT_CONFIG, 8'h00);
		cyc(2);
		chk("ctrl off", {5'h0, sup.comp_high_esr, sup.min_current_diag_en_b, sup.level_21v_req_a}, 8'h00);
		u_host.wr(ADDR_FAULT_FLAGS, 8'hff);
		rchk("status ro", ADDR_FAULT_FLAGS, 8'h00);
		rchk("unmapped", 8'h07, 8'h00);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock_i) faults <= dpr_faults_t'(8'h01 << i);
			cyc(DG + 10);
			rchk("status bit", ADDR_FAULT_FLAGS, 8'h01 << i);
			@(posedge clock_i) faults <= '0;
			cyc(8);
		end
		@(posedge clock_i) faults <= 8'h10;
		@(posedge clock_i);
		@(posedge clock_i) faults <= '0;
		cyc(4);
		rchk("short pdo", ADDR_FAULT_FLAGS, 8'h00);
		trip(8'h08, 8'h01, 2'b10, 8'h00, 2'b10);
		trip(8'h00, 8'h02, 2'b01, 8'h5a, 2'b11);
		trip(8'h40, 8'h40, 2'b00, 8'h00, 2'b00);
		trip(8'h00, 8'h40, 2'b00, 8'h5a, 2'b11);
		report_and_stop();
	end
endmodule
`default_nettype wire
